// ### rtl/sync_serial_regs.svh
// Register offsets, field positions, reset values and timing counts of the sync serial unit.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SYNC_SERIAL_REGS_SVH
`define SYNC_SERIAL_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the byte-wide register port
// ----------------------------------------------------------------------------
`define OFS_MODE_CLOCK_CTL   8'hA0
`define OFS_UPPER_DATA       8'hA1
`define OFS_LOWER_DATA       8'hA2
`define OFS_XFER_STATUS      8'hA3
`define OFS_IRQ_STATUS       8'hA4
`define OFS_IRQ_MASK         8'hA5

// ----------------------------------------------------------------------------
// Mode and clock control fields
// ----------------------------------------------------------------------------
`define CTL_MODE_HI          7
`define CTL_MODE_LO          6
`define CTL_CLK_SRC          3
`define CTL_DIV_HI           2
`define CTL_DIV_LO           0
`define CTL_WRITE_MASK       8'hCF
`define CTL_RESET            8'h00

// ----------------------------------------------------------------------------
// Transfer status fields
// ----------------------------------------------------------------------------
`define XST_START            0
`define XST_SO_LEVEL         1
`define XST_BUSY             2
`define XST_DONE             7
`define SO_RESET             1'b1

// ----------------------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------------------
`define IRQ_DONE             0
`define IRQ_COLLIDE          1
`define IRQ_WIDTH            2
`define IRQ_RESET            2'h0
`define DATA_RESET           8'h00

// ----------------------------------------------------------------------------
// Transfer lengths and prescaler half periods (system clock cycles minus one)
// ----------------------------------------------------------------------------
`define LEN_8BIT             5'h08
`define LEN_16BIT            5'h10
`define DIV_HALF_1024        9'h1FF
`define DIV_HALF_256         9'h07F
`define DIV_HALF_64          9'h01F
`define DIV_HALF_32          9'h00F
`define DIV_HALF_16          9'h007
`define DIV_HALF_8           9'h003
`define DIV_HALF_4           9'h001
`define DIV_HALF_2           9'h000
`define SCK_IDLE             1'b1

`endif

// ### rtl/sync_serial_pkg.sv
// Types shared by the sync serial unit.
// Assumes nothing of its surroundings.
`default_nettype none

package sync_serial_pkg;

  // Operation mode field encoding.
  typedef enum logic [1:0] {
    MODE_8BIT       = 2'h0,
    MODE_16BIT      = 2'h1,
    MODE_CONTINUOUS = 2'h2,
    MODE_RESERVED   = 2'h3
  } op_mode_type;

  // Transfer sequencer states.
  typedef enum logic {
    XFER_IDLE,
    XFER_SHIFT
  } xfer_state_type;

endpackage

`default_nettype wire

// ### rtl/serial_prescaler.sv
// Prescaler that produces one-cycle half-period ticks of the internal serial clock.
// Assumes a single system clock and an asynchronous active-low reset.
`include "sync_serial_regs.svh"
`default_nettype none

module serial_prescaler (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [2:0] div_code,
  output logic            tick
);

  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  // Half period of the serial clock for each divide code.
  function automatic logic [8:0] half_count(input logic [2:0] code);
    case (code)
      3'h0:    half_count = `DIV_HALF_1024;
      3'h1:    half_count = `DIV_HALF_256;
      3'h2:    half_count = `DIV_HALF_64;
      3'h3:    half_count = `DIV_HALF_32;
      3'h4:    half_count = `DIV_HALF_16;
      3'h5:    half_count = `DIV_HALF_8;
      3'h6:    half_count = `DIV_HALF_4;
      default: half_count = `DIV_HALF_2;
    endcase
  endfunction

  // Count down and reload; a stopped prescaler waits at its reload value.
  always_comb begin
    tick  = 1'b0;
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = half_count(div_code);
    end else if (cnt_q == 9'h000) begin
      tick  = 1'b1;
      cnt_d = half_count(div_code);
    end else begin
      cnt_d = cnt_q - 9'h001;
    end
  end

  // Counter register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

// ### rtl/pin_sync_edge.sv
// Two-flop synchroniser with edge detection for a pin from outside the clock domain.
// Assumes a single system clock; edges are seen in the same cycle as the synchronised level moves.
`default_nettype none

module pin_sync_edge #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // Only the second stage and later are looked at by logic.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
      last_q <= RESET_LEVEL;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Edge pulses from the settled stages.
  assign level = sync_q;
  assign rise  = sync_q & ~last_q;
  assign fall  = ~sync_q & last_q;

endmodule

`default_nettype wire

// ### rtl/sync_serial_unit.sv
// Clocked synchronous serial unit: mode and clock control, data bytes, status and interrupt.
// Assumes a byte-wide register port on mclk, and serial pins that come from outside the clock domain.
//
// Local design decision: strobed register access.
`include "sync_serial_regs.svh"
`default_nettype none

module sync_serial_unit (
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       serial_clock_pin_in,
  output logic            serial_clock_pin_out,
  output logic            serial_clock_pin_oe,
  output logic            serial_out_pin,
  input  wire logic       serial_in_pin,
  output logic            irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0]                     ctl_q;
  logic [7:0]                     ctl_d;
  logic [7:0]                     upper_q;
  logic [7:0]                     upper_d;
  logic [7:0]                     lower_q;
  logic [7:0]                     lower_d;
  logic                           so_q;
  logic                           so_d;
  logic                           done_q;
  logic                           done_d;
  logic [`IRQ_WIDTH-1:0]          irq_st_q;
  logic [`IRQ_WIDTH-1:0]          irq_st_d;
  logic [`IRQ_WIDTH-1:0]          irq_mask_q;
  logic [`IRQ_WIDTH-1:0]          irq_mask_d;
  sync_serial_pkg::xfer_state_type state_q;
  sync_serial_pkg::xfer_state_type state_d;
  logic [4:0]                     cnt_q;
  logic [4:0]                     cnt_d;
  logic                           sck_q;
  logic                           sck_d;
  logic [7:0]                     rdata_q;
  logic [7:0]                     rdata_d;

  // --------------------------------------------------------------------------
  // Decoded fields and helpers
  // --------------------------------------------------------------------------
  sync_serial_pkg::op_mode_type mode;
  logic                         ext_clk;
  logic                         tick;
  logic                         ext_rise;
  logic                         ext_fall;
  logic                         si_level;
  logic                         shift_rise;
  logic                         shift_fall;
  logic                         prescaler_run;
  logic [4:0]                   xfer_len;
  logic [`IRQ_WIDTH-1:0]        irq_event;

  // Field decode of the mode and clock control register.
  assign mode    = sync_serial_pkg::op_mode_type'(ctl_q[`CTL_MODE_HI:`CTL_MODE_LO]);
  assign ext_clk = ctl_q[`CTL_CLK_SRC];

  // The prescaler runs while an internal clock is needed.
  assign prescaler_run = !ext_clk &&
                         (state_q == sync_serial_pkg::XFER_SHIFT ||
                          mode == sync_serial_pkg::MODE_CONTINUOUS);

  // Internal serial clock ticks.
  serial_prescaler u_prescaler (
    .mclk     (mclk),
    .resetn   (resetn),
    .run      (prescaler_run),
    .div_code (ctl_q[`CTL_DIV_HI:`CTL_DIV_LO]),
    .tick     (tick)
  );

  // External serial clock, synchronised before use.
  pin_sync_edge #(
    .RESET_LEVEL (`SCK_IDLE)
  ) u_sck_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin    (serial_clock_pin_in),
    .level  (),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  // Serial data input, synchronised before use.
  pin_sync_edge #(
    .RESET_LEVEL (1'b0)
  ) u_si_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pin    (serial_in_pin),
    .level  (si_level),
    .rise   (),
    .fall   ()
  );

  // Shift clock edges come from the pin or from the internal clock register.
  always_comb begin
    if (ext_clk) begin
      shift_rise = ext_rise;
      shift_fall = ext_fall;
    end else begin
      shift_rise = tick && !sck_q;
      shift_fall = tick && sck_q;
    end
  end

  // Number of bits in one transfer for the selected mode.
  function automatic logic [4:0] length_of(input sync_serial_pkg::op_mode_type m);
    if (m == sync_serial_pkg::MODE_16BIT) begin
      length_of = `LEN_16BIT;
    end else begin
      length_of = `LEN_8BIT;
    end
  endfunction

  assign xfer_len = length_of(mode);

  // --------------------------------------------------------------------------
  // Register writes, transfer sequencer and pin levels
  // --------------------------------------------------------------------------
  // Software writes are applied first; hardware events then override them.
  always_comb begin
    ctl_d      = ctl_q;
    upper_d    = upper_q;
    lower_d    = lower_q;
    so_d       = so_q;
    done_d     = done_q;
    irq_mask_d = irq_mask_q;
    irq_st_d   = irq_st_q;
    state_d    = state_q;
    cnt_d      = cnt_q;
    sck_d      = sck_q;
    irq_event  = '0;

    if (reg_wr) begin
      unique case (reg_addr)
        `OFS_MODE_CLOCK_CTL: begin
          ctl_d = reg_wdata & `CTL_WRITE_MASK;
        end
        `OFS_UPPER_DATA: begin
          upper_d = reg_wdata;
        end
        `OFS_LOWER_DATA: begin
          lower_d = reg_wdata;
        end
        `OFS_XFER_STATUS: begin
          so_d = reg_wdata[`XST_SO_LEVEL];
          if (!reg_wdata[`XST_DONE]) begin
            done_d = 1'b0;
          end
          if (reg_wdata[`XST_START]) begin
            if (state_q == sync_serial_pkg::XFER_SHIFT) begin
              irq_event[`IRQ_COLLIDE] = 1'b1;
            end else if (mode == sync_serial_pkg::MODE_8BIT || mode == sync_serial_pkg::MODE_16BIT) begin
              state_d = sync_serial_pkg::XFER_SHIFT;
              cnt_d   = '0;
            end
          end
        end
        `OFS_IRQ_STATUS: begin
          irq_st_d = irq_st_q & ~reg_wdata[`IRQ_WIDTH-1:0];
        end
        `OFS_IRQ_MASK: begin
          irq_mask_d = reg_wdata[`IRQ_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end

    // Internal clock toggles on each prescaler tick, and idles high otherwise.
    if (prescaler_run) begin
      if (tick) begin
        sck_d = ~sck_q;
      end
    end else begin
      sck_d = `SCK_IDLE;
    end

    // Falling edge presents the next bit; rising edge captures the input bit.
    if (state_q == sync_serial_pkg::XFER_SHIFT) begin
      if (shift_fall) begin
        so_d = lower_q[0];
      end
      if (shift_rise) begin
        if (mode == sync_serial_pkg::MODE_16BIT) begin
          {upper_d, lower_d} = {si_level, upper_q, lower_q[7:1]};
        end else begin
          lower_d = {si_level, lower_q[7:1]};
        end
        cnt_d = cnt_q + 5'h01;
        if (cnt_d == xfer_len) begin
          state_d                = sync_serial_pkg::XFER_IDLE;
          done_d                 = 1'b1;
          irq_event[`IRQ_DONE]   = 1'b1;
        end
      end
    end

    // New events set their status bits after any clear by software.
    irq_st_d = irq_st_d | irq_event;
  end

  // Register stage for control, data and sequencer state.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctl_q      <= `CTL_RESET;
      upper_q    <= `DATA_RESET;
      lower_q    <= `DATA_RESET;
      so_q       <= `SO_RESET;
      done_q     <= 1'b0;
      irq_st_q   <= `IRQ_RESET;
      irq_mask_q <= `IRQ_RESET;
      state_q    <= sync_serial_pkg::XFER_IDLE;
      cnt_q      <= '0;
      sck_q      <= `SCK_IDLE;
    end else begin
      ctl_q      <= ctl_d;
      upper_q    <= upper_d;
      lower_q    <= lower_d;
      so_q       <= so_d;
      done_q     <= done_d;
      irq_st_q   <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      sck_q      <= sck_d;
    end
  end

  // --------------------------------------------------------------------------
  // Register reads
  // --------------------------------------------------------------------------
  // Read data is computed from the current state and stands for one cycle.
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `OFS_MODE_CLOCK_CTL: begin
          rdata_d = ctl_q & `CTL_WRITE_MASK;
        end
        `OFS_UPPER_DATA: begin
          rdata_d = upper_q;
        end
        `OFS_LOWER_DATA: begin
          rdata_d = lower_q;
        end
        `OFS_XFER_STATUS: begin
          rdata_d[`XST_SO_LEVEL] = so_q;
          rdata_d[`XST_BUSY]     = (state_q == sync_serial_pkg::XFER_SHIFT);
          rdata_d[`XST_DONE]     = done_q;
        end
        `OFS_IRQ_STATUS: begin
          rdata_d[`IRQ_WIDTH-1:0] = irq_st_q;
        end
        `OFS_IRQ_MASK: begin
          rdata_d[`IRQ_WIDTH-1:0] = irq_mask_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Pins and interrupt come straight from registers.
  assign reg_rdata            = rdata_q;
  assign serial_clock_pin_out = sck_q;
  assign serial_clock_pin_oe  = ~ext_clk;
  assign serial_out_pin       = so_q;
  assign irq                  = |(irq_st_q & irq_mask_q);

endmodule

`default_nettype wire

// ### verification/sync_serial_unit_properties.sv
// Concurrent checks on the ports of the sync serial unit.
// Assumes binding to sync_serial_unit, one clock domain on mclk.
`default_nettype none

module sync_serial_unit_properties (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       serial_clock_pin_in,
  input wire logic       serial_clock_pin_out,
  input wire logic       serial_clock_pin_oe,
  input wire logic       serial_out_pin,
  input wire logic       serial_in_pin,
  input wire logic       irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // Register accesses that the checks start from.
  sequence ctl_wr;
    reg_wr && reg_addr == 8'hA0;
  endsequence
  sequence ctl_rd;
    reg_rd && reg_addr == 8'hA0;
  endsequence
  sequence st_wr;
    reg_wr && reg_addr == 8'hA3 && !reg_wdata[0];
  endsequence

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  so_low_a: assert property (st_wr ##0 !reg_wdata[1] |=> !serial_out_pin)
    else $error("output level write 0 not seen on pin");
  so_high_a: assert property (st_wr ##0 reg_wdata[1] |=> serial_out_pin)
    else $error("output level write 1 not seen on pin");
  level_read_a: assert property (reg_rd && reg_addr == 8'hA3 |=> reg_rdata[1] == $past(serial_out_pin))
    else $error("level read differs from pin");
  ctl_reserved_a: assert property (ctl_rd |=> reg_rdata[5:4] == 2'b00)
    else $error("reserved control bits read nonzero");
  ctl_readback_a: assert property (ctl_wr ##2 ctl_rd |=> reg_rdata == ($past(reg_wdata, 3) & 8'hCF))
    else $error("control readback wrong");
  oe_select_a: assert property (ctl_wr |=> serial_clock_pin_oe == !$past(reg_wdata[3]))
    else $error("clock pin direction wrong");
  oe_stable_a: assert property ($changed(serial_clock_pin_oe) |-> $past(reg_wr && reg_addr == 8'hA0))
    else $error("clock pin direction moved without a write");
  so_cause_a: assert property (serial_clock_pin_oe && $changed(serial_out_pin)
    |-> $past(reg_wr && reg_addr == 8'hA3) || !serial_clock_pin_out)
    else $error("data output moved off a falling clock");
  mask_zero_a: assert property (reg_wr && reg_addr == 8'hA5 && reg_wdata[1:0] == 2'b00 |=> ##1 !irq)
    else $error("interrupt high with all masked");
endmodule

`default_nettype wire

// ### verification/serial_peer.sv
// Model of the external serial peer: sends its word LSB first and captures the unit's bits.
// Assumes the resolved clock pin level at sck; drives its own clock only on ext_go.
`default_nettype none

module serial_peer #(
  parameter int HALF_NS = 430
) (
  input  wire logic        mclk,
  input  wire logic        sck,
  input  wire logic        so,
  input  wire logic        arm,
  input  wire logic        ext_go,
  input  wire logic [15:0] tx_word,
  input  wire logic [4:0]  n_bits,
  output logic             sck_drv,
  output logic             si,
  output logic [15:0]      rx_word
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx;

  // Clock bursts of n_bits periods, standing high between frames.
  initial begin
    sck_drv = 1'b1;
    forever begin
      @(posedge ext_go);
      repeat (n_bits) begin
        #HALF_NS sck_drv = 1'b0;
        #HALF_NS sck_drv = 1'b1;
      end
    end
  end

  // Next bit leaves on the falling edge.
  always @(negedge sck) begin
    if (idx < 32'(n_bits))
      si <= tx_word[idx[3:0]];
    idx <= idx + 1;
  end

  // Capture on the rising edge; half a period after the frame's last edge the data line stops holding.
  // Letting go at the edge itself would break hold time for the unit's last sample of the data line.
  always @(posedge sck) begin
    rx_word <= {so, rx_word[15:1]};
    if (idx >= 32'(n_bits))
      si <= #HALF_NS ~si;
  end

  // A new frame restarts the bit index.
  always @(posedge mclk) begin
    if (arm)
      idx <= 0;
  end

  initial begin
    si = 1'b1;
    idx = 16;
    rx_word = 16'h0000;
  end
endmodule

`default_nettype wire

// ### verification/tb.sv
// Self-checking bench for the sync serial unit with a serial peer model.
// Assumes the design files and the checker are compiled before it.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        sck_o, sck_oe, sck_x, sck_w, so, si, irq, arm, ext_go;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic [4:0]  n_bits;
  int          n_mismatch;
  int          n_compared;
  time         t0;
  logic [15:0] div_tab [8] = '{16'h0400, 16'h0100, 16'h0040, 16'h0020, 16'h0010, 16'h0008, 16'h0004, 16'h0002};

  // Clock pin level from whichever side drives it.
  assign sck_w = sck_oe ? sck_o : sck_x;

  sync_serial_unit i_dut (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_clock_pin_in(sck_w),
    .serial_clock_pin_out(sck_o), .serial_clock_pin_oe(sck_oe), .serial_out_pin(so),
    .serial_in_pin(si), .irq(irq)
  );
  serial_peer i_peer (
    .mclk(mclk), .sck(sck_w), .so(so), .arm(arm), .ext_go(ext_go), .tx_word(tx_word),
    .n_bits(n_bits), .sck_drv(sck_x), .si(si), .rx_word(rx_word)
  );

  // ------------------------------------------------------------
  // Access tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(what, 16'(d), 16'(e));
  endtask
  // Starts a frame after arming the peer; polls the done flag under a bound.
  task automatic xfer(input logic [15:0] w, input logic [4:0] n, input logic ext);
    logic [7:0] d;
    d = 8'h00;
    tx_word <= w;
    n_bits <= n;
    arm <= 1'b1;
    @(posedge mclk);
    arm <= 1'b0;
    wr(8'hA3, 8'h03);
    ext_go <= ext;
    @(posedge mclk);
    ext_go <= 1'b0;
    if (ext)
      wr(8'hA3, 8'h03);
    for (int i = 0; i < 400 && !d[7]; i++)
      rd(8'hA3, d);
    chk("done status", 16'(d), 16'h0082);
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #3_000_000;
    n_mismatch++;
    conclude();
  end

  initial begin
    {resetn, reg_wr, reg_rd, arm, ext_go} = 5'h00;
    {reg_addr, reg_wdata, tx_word, n_bits} = 37'h0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rdc("ctl reset", 8'hA0, 8'h00);
    rdc("status reset", 8'hA3, 8'h02);
    rdc("unmapped", 8'hB7, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'hA0, {m[1:0], 6'h3F});
      rdc("ctl mode", 8'hA0, {m[1:0], 6'h0F});
    end
    $display("register test done");
    wr(8'hA0, 8'h04);
    chk("clock oe", 16'(sck_oe), 16'h0001);
    wr(8'hA3, 8'h00);
    chk("so low", 16'(so), 16'h0000);
    rdc("level low", 8'hA3, 8'h00);
    wr(8'hA3, 8'h02);
    chk("so high", 16'(so), 16'h0001);
    $display("level test done");
    wr(8'hA1, 8'h5A);
    wr(8'hA2, 8'hC3);
    xfer(16'h0096, 5'h08, 1'b0);
    chk("peer rx 8", 16'(rx_word[15:8]), 16'h00C3);
    rdc("lower rx", 8'hA2, 8'h96);
    rdc("upper kept", 8'hA1, 8'h5A);
    rdc("irq status", 8'hA4, 8'h01);
    chk("irq masked", 16'(irq), 16'h0000);
    wr(8'hA5, 8'h01);
    chk("irq on", 16'(irq), 16'h0001);
    wr(8'hA3, 8'h82);
    rdc("done kept", 8'hA3, 8'h82);
    wr(8'hA3, 8'h02);
    rdc("done cleared", 8'hA3, 8'h02);
    wr(8'hA4, 8'h01);
    chk("irq cleared", 16'(irq), 16'h0000);
    $display("8-bit test done");
    wr(8'hA0, 8'h48);
    chk("clock input", 16'(sck_oe), 16'h0000);
    wr(8'hA1, 8'hA5);
    wr(8'hA2, 8'h3C);
    xfer(16'hBEEF, 5'h10, 1'b1);
    chk("peer rx 16", rx_word, 16'hA53C);
    rdc("upper rx", 8'hA1, 8'hBE);
    rdc("lower rx 16", 8'hA2, 8'hEF);
    rdc("irq collide", 8'hA4, 8'h03);
    chk("irq done", 16'(irq), 16'h0001);
    wr(8'hA5, 8'h00);
    chk("irq all masked", 16'(irq), 16'h0000);
    $display("16-bit test done");
    for (int c = 0; c < 8; c++) begin
      wr(8'hA0, 8'h80 | 8'(c));
      @(negedge sck_o);
      @(negedge sck_o);
      t0 = $time;
      @(negedge sck_o);
      chk("sck period", 16'(($time - t0) / 100), div_tab[c]);
      @(posedge mclk);
    end
    $display("divider test done");
    conclude();
  end
endmodule

bind sync_serial_unit sync_serial_unit_properties i_props (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_clock_pin_in(serial_clock_pin_in), .serial_clock_pin_out(serial_clock_pin_out),
  .serial_clock_pin_oe(serial_clock_pin_oe), .serial_out_pin(serial_out_pin),
  .serial_in_pin(serial_in_pin), .irq(irq)
);

`default_nettype wire
